// >>> sgm_params.svh
// Constants of the serial MAC interface selection block
`ifndef SGM_PARAMS_SVH
`define SGM_PARAMS_SVH

// Speed codes, as carried in the serial link config word
`define SGM_SPD_10       2'h0
`define SGM_SPD_100      2'h1
`define SGM_SPD_1000     2'h2

// Byte replication counts per speed on the serial link
`define SGM_REP_10M      7'h64
`define SGM_REP_100M     7'h0A
`define SGM_REP_1G       7'h01
`define SGM_REP_W        7

// Link config word layout
`define SGM_CW_W         16
`define SGM_CW_LINK      15
`define SGM_CW_DUPLEX    12
`define SGM_CW_SPD_HI    11
`define SGM_CW_SPD_LO    10
`define SGM_CW_SGMII     0

// Reset values and buffer shape
`define SGM_AN_RST       1'h1
`define SGM_FIFO_DEPTH   8

`endif

// >>> sgm_pkg.sv
// Types shared by the serial MAC interface selection block
package sgm_pkg;

    // MAC interface mode, Gray coded along off -> parallel -> serial
    typedef enum logic [1:0] {
        SGM_MODE_OFF = 2'b00,
        SGM_MODE_PAR = 2'b01,
        SGM_MODE_SER = 2'b11
    } sgm_mode_t;

    // One frame byte with its start-of-frame marker
    typedef struct packed {
        logic       sof;
        logic [7:0] data;
    } sgm_byte_t;

    // Latched strap values
    typedef struct packed {
        logic serial_en;
        logic parallel_dis;
    } sgm_strap_t;

endpackage : sgm_pkg

// >>> sgm_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module sgm_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    ////////////////////////////////////////////////////////////////////////
    // Honest full and empty from the occupancy count
    assign wr_ready_out = (count_reg != (AW + 1)'(DEPTH));
    assign rd_valid_out = (count_reg != '0);
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;
    assign rd_data_out  = mem[rd_ptr_reg];

    // Storage; no reset needed, guarded by the count
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr_reg] <= wr_data_in;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_reg <= '0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end

endmodule : sgm_fifo

// >>> sgm_mac_if.sv
// MAC interface selection and serial link adaptation
`include "sgm_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - A set serial enable selects serial mode regardless of the parallel enable, else parallel if enabled, else off.
// - The serial enable bit starts from the serial-enable strap caught after reset.
// - The latched serial-enable and parallel-disable straps are readable as strap status.
// - At 100 Mb on the serial link each byte is sent 10 times while start of frame shows once.
// - The link advertises the media-resolved speed, or in MAC loopback the media speed selection, to the MAC via auto-negotiation.
// - Link auto-negotiation is on after reset; cleared, the speed is forced to the media speed.
// - Forced serial speed works with media auto-negotiation and with manual media speed.
// - In MAC loopback the serial speed follows the media speed selection, in either link mode.
// - Default link is one transmit and one receive pair, transmit data taken with no clock.
// - Optionally a receive clock is driven on a third pair for MACs without clock recovery.
module sgm_mac_if
    import sgm_pkg::*;
#(
    parameter int FIFO_DEPTH = `SGM_FIFO_DEPTH
) (
    input  wire logic       ref_clk_in,
    input  wire logic       rst_in,
    input  wire logic       serial_enable_strap_pin_in,
    input  wire logic       parallel_dis_strap_in,
    input  wire logic       phy_ctl_wr_in,
    input  wire logic       phy_ctl_serial_en_in,
    input  wire logic       parallel_enable_in,
    input  wire logic       second_config_wr_in,
    input  wire logic       serial_autoneg_enable_in,
    input  wire logic       ten_meg_serial_rate_adapt_in,
    input  wire logic       six_wire_enable_in,
    input  wire logic       mac_loopback_in,
    input  wire logic [1:0] mdi_speed_sel_in,
    input  wire logic       media_link_in,
    input  wire logic [1:0] media_speed_in,
    input  wire logic       media_duplex_in,
    input  wire sgm_byte_t  media_rx_in,
    input  wire logic       media_rx_valid_in,
    output logic            media_rx_ready_out,
    output sgm_byte_t       mac_rx_out,
    output logic            mac_rx_valid_out,
    input  wire logic       mac_rx_ready_in,
    input  wire logic [7:0] mac_tx_in,
    input  wire logic       mac_tx_valid_in,
    output logic [7:0]      media_tx_out,
    output logic            media_tx_valid_out,
    output sgm_mode_t       mode_out,
    output sgm_strap_t      strap_status_one_out,
    output logic            phy_serial_enable_out,
    output logic            serial_autoneg_enable_out,
    output logic [1:0]      serial_speed_out,
    output logic [15:0]     an_word_out,
    output logic            rx_clk_p_out,
    output logic            rx_clk_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic                  strap_s1_reg;
    logic                  strap_s2_reg;
    logic                  pdis_s1_reg;
    logic                  pdis_s2_reg;
    logic                  link_s1_reg;
    logic                  link_s2_reg;
    logic [1:0]            spd_s1_reg;
    logic [1:0]            spd_s2_reg;
    logic [1:0]            spd_s3_reg;
    logic [1:0]            spd_q_reg;
    logic                  dup_s1_reg;
    logic                  dup_s2_reg;
    logic                  link_d_reg;
    logic                  strap_taken_reg;
    sgm_strap_t            strap_status_reg;
    logic                  ser_en_reg;
    sgm_mode_t             mode_reg;
    logic                  an_en_reg;
    logic [1:0]            forced_spd_reg;
    logic [`SGM_CW_W-1:0]  an_word_reg;
    logic                  clk_p_reg;
    logic                  clk_n_reg;
    logic [7:0]            tx_data_reg;
    logic                  tx_valid_reg;
    sgm_byte_t             hold_reg;
    logic                  hold_valid_reg;
    logic [`SGM_REP_W-1:0] rep_cnt_reg;
    logic [`SGM_REP_W-1:0] rep_target;
    logic [1:0]            media_spd;
    logic [1:0]            eff_spd;
    logic                  link_rise;
    logic                  path_ok;
    logic                  last_copy;
    logic                  out_fire;
    logic                  fifo_rd_ready;
    logic                  fifo_rd_valid;
    sgm_byte_t             fifo_rd_data;
    logic                  is_serial;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage is read only by the second
    always_ff @(posedge ref_clk_in) begin
        strap_s1_reg <= serial_enable_strap_pin_in;
        strap_s2_reg <= strap_s1_reg;
        pdis_s1_reg  <= parallel_dis_strap_in;
        pdis_s2_reg  <= pdis_s1_reg;
        link_s1_reg  <= media_link_in;
        link_s2_reg  <= link_s1_reg;
        spd_s1_reg   <= media_speed_in;
        spd_s2_reg   <= spd_s1_reg;
        spd_s3_reg   <= spd_s2_reg;
        dup_s1_reg   <= media_duplex_in;
        dup_s2_reg   <= dup_s1_reg;
    end

    // Speed crosses as two bits; take it only once two samples agree
    always_ff @(posedge ref_clk_in) begin
        if (spd_s2_reg == spd_s3_reg) begin
            spd_q_reg <= spd_s2_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap capture once after reset release; reset must last two edges
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            strap_taken_reg  <= 1'b0;
            strap_status_reg <= '0;
        end else if (!strap_taken_reg) begin
            strap_taken_reg  <= 1'b1;
            strap_status_reg <= '{serial_en: strap_s2_reg,
                                   parallel_dis: pdis_s2_reg};
        end
    end

    // Serial enable bit: strap seeds it, software may overwrite later
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            ser_en_reg <= 1'b0;
        end else if (!strap_taken_reg) begin
            ser_en_reg <= strap_s2_reg;
        end else if (phy_ctl_wr_in) begin
            ser_en_reg <= phy_ctl_serial_en_in;
        end
    end

    // Mode selection; serial enable outranks the parallel enable
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            mode_reg <= SGM_MODE_OFF;
        end else if (ser_en_reg) begin
            mode_reg <= SGM_MODE_SER;
        end else if (parallel_enable_in) begin
            mode_reg <= SGM_MODE_PAR;
        end else begin
            mode_reg <= SGM_MODE_OFF;
        end
    end

    assign is_serial = (mode_reg == SGM_MODE_SER);

    ////////////////////////////////////////////////////////////////////////
    // Link auto-negotiation enable, on after reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            an_en_reg <= `SGM_AN_RST;
        end else if (second_config_wr_in) begin
            an_en_reg <= serial_autoneg_enable_in;
        end
    end

    // Loopback takes the media speed selection, not the resolved one
    assign media_spd = mac_loopback_in ? mdi_speed_sel_in : spd_q_reg;
    assign link_rise = link_s2_reg && !link_d_reg;

    // Forced speed is refreshed at each new link and while negotiating, so
    // the value is current whether the media side negotiates or is manual
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            link_d_reg     <= 1'b0;
            forced_spd_reg <= `SGM_SPD_1000;
        end else begin
            link_d_reg <= link_s2_reg;
            if (an_en_reg || link_rise || mac_loopback_in) begin
                forced_spd_reg <= media_spd;
            end
        end
    end

    assign eff_spd = an_en_reg ? media_spd : forced_spd_reg;

    // Advertised config word toward the MAC, zero while forced
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            an_word_reg <= '0;
        end else if (an_en_reg && is_serial) begin
            an_word_reg                                  <= '0;
            an_word_reg[`SGM_CW_LINK]                    <= link_s2_reg;
            an_word_reg[`SGM_CW_DUPLEX]                  <= dup_s2_reg;
            an_word_reg[`SGM_CW_SPD_HI:`SGM_CW_SPD_LO]   <= media_spd;
            an_word_reg[`SGM_CW_SGMII]                   <= 1'b1;
        end else begin
            an_word_reg <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Optional receive clock pair, toggles only in six-wire serial mode
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !(six_wire_enable_in && is_serial)) begin
            clk_p_reg <= 1'b0;
            clk_n_reg <= 1'b0;
        end else begin
            clk_p_reg <= !clk_p_reg;
            clk_n_reg <= clk_p_reg;
        end
    end

    // Transmit bytes sampled on the local clock, no MAC clock needed
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            tx_data_reg  <= '0;
            tx_valid_reg <= 1'b0;
        end else begin
            tx_data_reg  <= mac_tx_in;
            tx_valid_reg <= mac_tx_valid_in && (mode_reg != SGM_MODE_OFF);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer; back-pressure reaches the media side
    sgm_fifo #(
        .WIDTH ($bits(sgm_byte_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_in   (ref_clk_in),
        .rst_in       (rst_in),
        .wr_data_in   (media_rx_in),
        .wr_valid_in  (media_rx_valid_in),
        .wr_ready_out (media_rx_ready_out),
        .rd_data_out  (fifo_rd_data),
        .rd_valid_out (fifo_rd_valid),
        .rd_ready_in  (fifo_rd_ready)
    );

    // Copies per byte; 10 Mb serial stalls while rate adapt is still set
    always_comb begin
        rep_target = `SGM_REP_1G;
        path_ok    = 1'b1;
        if (is_serial) begin
            unique case (eff_spd)
                `SGM_SPD_100: rep_target = `SGM_REP_100M;
                `SGM_SPD_10: begin
                    rep_target = `SGM_REP_10M;
                    path_ok    = !ten_meg_serial_rate_adapt_in;
                end
                default:      rep_target = `SGM_REP_1G;
            endcase
        end
    end

    assign last_copy     = (rep_cnt_reg == rep_target - 1'b1);
    assign out_fire      = hold_valid_reg && mac_rx_ready_in;
    assign fifo_rd_ready = path_ok && (!hold_valid_reg || (out_fire && last_copy));

    // Replicator; the start marker rides only the first copy
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            hold_reg       <= '0;
            hold_valid_reg <= 1'b0;
            rep_cnt_reg    <= '0;
        end else if (fifo_rd_ready && fifo_rd_valid) begin
            hold_reg       <= fifo_rd_data;
            hold_valid_reg <= 1'b1;
            rep_cnt_reg    <= '0;
        end else if (out_fire) begin
            hold_reg.sof <= 1'b0;
            if (last_copy) begin
                hold_valid_reg <= 1'b0;
                rep_cnt_reg    <= '0;
            end else begin
                rep_cnt_reg <= rep_cnt_reg + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign mac_rx_out                = hold_reg;
    assign mac_rx_valid_out          = hold_valid_reg;
    assign media_tx_out              = tx_data_reg;
    assign media_tx_valid_out        = tx_valid_reg;
    assign mode_out                  = mode_reg;
    assign strap_status_one_out      = strap_status_reg;
    assign phy_serial_enable_out     = ser_en_reg;
    assign serial_autoneg_enable_out = an_en_reg;
    assign serial_speed_out          = eff_spd;
    assign an_word_out               = an_word_reg;
    assign rx_clk_p_out              = clk_p_reg;
    assign rx_clk_n_out              = clk_n_reg;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    serial_prio_a: assert property (ser_en_reg |=> mode_reg == SGM_MODE_SER)
        else $error("serial enable did not select serial mode");
    parallel_sel_a: assert property (!ser_en_reg && parallel_enable_in
        |=> mode_reg == SGM_MODE_PAR)
        else $error("parallel mode not selected");
    strap_seed_a: assert property ($rose(strap_taken_reg)
        |-> ser_en_reg == strap_status_reg.serial_en)
        else $error("serial enable not seeded from strap");
    strap_hold_a: assert property (strap_taken_reg && $past(strap_taken_reg)
        |-> $stable(strap_status_reg))
        else $error("strap status changed after capture");
    rep_bound_a: assert property (hold_valid_reg |-> rep_cnt_reg < rep_target)
        else $error("replication count beyond target");
    // Nine quiet copies follow the first, split 8 plus 1 to keep the unroll small
    sof_once_a: assert property (out_fire && mac_rx_out.sof && rep_target == `SGM_REP_100M
        |=> !mac_rx_out.sof [*8] ##1 !mac_rx_out.sof)
        else $error("start of frame repeated");
    an_reset_a: assert property ($fell(rst_in) |-> an_en_reg)
        else $error("auto-negotiation off after reset");
    forced_track_a: assert property (!an_en_reg && link_rise
        |=> forced_spd_reg == $past(media_spd))
        else $error("forced speed missed new link");
    advert_a: assert property (an_en_reg && is_serial
        |=> an_word_out[`SGM_CW_SPD_HI:`SGM_CW_SPD_LO] == $past(media_spd))
        else $error("advertised speed wrong");
    loop_spd_a: assert property (mac_loopback_in && an_en_reg
        |-> serial_speed_out == mdi_speed_sel_in)
        else $error("loopback speed not from selection");
    rxclk_off_a: assert property (!six_wire_enable_in |=> !rx_clk_p_out && !rx_clk_n_out)
        else $error("receive clock driven in four-wire mode");
    ten_stall_a: assert property (is_serial && eff_spd == `SGM_SPD_10
        && ten_meg_serial_rate_adapt_in |-> !fifo_rd_ready)
        else $error("10 Mb path drained with rate adapt set");

    hundred_c: cover property (rep_target == `SGM_REP_100M && out_fire && last_copy);
    forced_c: cover property (!an_en_reg && link_rise);
    fifo_full_c: cover property (!media_rx_ready_out);
    six_wire_c: cover property ($rose(rx_clk_p_out));

endmodule : sgm_mac_if

// >>> sgm_mac_model.sv
// Behavioural MAC facing the receive stream and link config word
`include "sgm_params.svh"
module sgm_mac_model
    import sgm_pkg::*;
(
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    input  wire logic        clr_in,
    input  wire logic [1:0]  pace_in,
    input  wire sgm_byte_t   rx_in,
    input  wire logic        rx_valid_in,
    output logic             rx_ready_out,
    input  wire logic [15:0] an_word_in,
    output logic [15:0]      beats_out,
    output logic [15:0]      sofs_out,
    output logic [7:0]       last_out,
    output logic [1:0]       an_speed_out
);
    logic alt_reg;

    ////////////////////////////////////////////////////////////////////////
    // Pace 0 always ready, 1 every other cycle, 2 stalled; a real MAC stalls
    always_ff @(posedge ref_clk_in) begin
        alt_reg <= rst_in ? 1'b0 : ~alt_reg;
    end
    assign rx_ready_out = (pace_in == 2'h0) | ((pace_in == 2'h1) & alt_reg);

    // Count accepted beats and frame starts; data taken with no forwarded clock
    always_ff @(posedge ref_clk_in) begin
        if (rst_in | clr_in) begin
            beats_out <= 16'h0000;
            sofs_out  <= 16'h0000;
        end else if (rx_valid_in & rx_ready_out) begin
            beats_out <= beats_out + 16'h0001;
            sofs_out  <= sofs_out + {15'h0000, rx_in.sof};
            last_out  <= rx_in.data;
        end
    end

    // Speed the MAC resolves from the advertised word, only when marked valid
    assign an_speed_out = an_word_in[`SGM_CW_SGMII] ?
        an_word_in[`SGM_CW_SPD_HI:`SGM_CW_SPD_LO] : 2'h3;
endmodule : sgm_mac_model

// >>> sgm_mac_if_tb.sv
// Self-checking bench of the MAC interface selection block
`include "sgm_params.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module sgm_mac_if_tb
    import sgm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic      ser;
        logic      par;
        sgm_mode_t mode;
        logic      txv;
    } sgm_row_t;
    localparam sgm_row_t ROWS [4] = '{'{1'b1, 1'b1, SGM_MODE_SER, 1'b1},
        '{1'b1, 1'b0, SGM_MODE_SER, 1'b1}, '{1'b0, 1'b1, SGM_MODE_PAR, 1'b1},
        '{1'b0, 1'b0, SGM_MODE_OFF, 1'b0}};
    logic ref_clk_in = 1'b0, rst_in = 1'b1, serial_enable_strap_pin_in = 1'b1;
    logic parallel_dis_strap_in = 1'b0, phy_ctl_wr_in = 1'b0, phy_ctl_serial_en_in = 1'b0;
    logic parallel_enable_in = 1'b0, second_config_wr_in = 1'b0, serial_autoneg_enable_in = 1'b1;
    logic ten_meg_serial_rate_adapt_in = 1'b0, six_wire_enable_in = 1'b0;
    logic mac_loopback_in = 1'b0, media_link_in = 1'b1, media_duplex_in = 1'b1;
    logic [1:0] mdi_speed_sel_in = 2'h2, media_speed_in = 2'h2, pace = 2'h0;
    sgm_byte_t media_rx_in = '0, mac_rx_out;
    logic media_rx_valid_in = 1'b0, media_rx_ready_out, mac_rx_valid_out, mac_rx_ready_in;
    logic [7:0] mac_tx_in = 8'h00, media_tx_out, last, a;
    logic mac_tx_valid_in = 1'b0, media_tx_valid_out, phy_serial_enable_out, clr = 1'b0;
    logic serial_autoneg_enable_out, rx_clk_p_out, rx_clk_n_out, refused;
    logic [1:0] serial_speed_out, an_speed;
    logic [15:0] an_word_out, beats, sofs;
    sgm_mode_t mode_out;
    sgm_strap_t strap_status_one_out;
    int failures = 0, cmp_count = 0, cycles = 0, acc;

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side MAC
    sgm_mac_if #(.FIFO_DEPTH(8)) dut (.ref_clk_in, .rst_in, .serial_enable_strap_pin_in,
        .parallel_dis_strap_in, .phy_ctl_wr_in, .phy_ctl_serial_en_in, .parallel_enable_in,
        .second_config_wr_in, .serial_autoneg_enable_in, .ten_meg_serial_rate_adapt_in,
        .six_wire_enable_in, .mac_loopback_in, .mdi_speed_sel_in, .media_link_in,
        .media_speed_in, .media_duplex_in, .media_rx_in, .media_rx_valid_in,
        .media_rx_ready_out, .mac_rx_out, .mac_rx_valid_out, .mac_rx_ready_in, .mac_tx_in,
        .mac_tx_valid_in, .media_tx_out, .media_tx_valid_out, .mode_out,
        .strap_status_one_out, .phy_serial_enable_out, .serial_autoneg_enable_out,
        .serial_speed_out, .an_word_out, .rx_clk_p_out, .rx_clk_n_out);
    sgm_mac_model mac (.ref_clk_in, .rst_in, .clr_in(clr), .pace_in(pace), .rx_in(mac_rx_out),
        .rx_valid_in(mac_rx_valid_out), .rx_ready_out(mac_rx_ready_in),
        .an_word_in(an_word_out), .beats_out(beats), .sofs_out(sofs), .last_out(last),
        .an_speed_out(an_speed));

    // Clock and hang guard, ceiling well above the planned run
    always #5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            wrap_up();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk_in);
    endtask : tick
    task automatic wr_ctl(input logic v, input logic an);
        @(negedge ref_clk_in);
        phy_ctl_wr_in = ~an;
        second_config_wr_in = an;
        phy_ctl_serial_en_in = v;
        serial_autoneg_enable_in = v;
        tick(1);
        phy_ctl_wr_in = 1'b0;
        second_config_wr_in = 1'b0;
    endtask : wr_ctl
    // Hold valid and byte until the FIFO takes it, then release
    task automatic push(input logic [7:0] d, input logic s);
        int i;
        @(negedge ref_clk_in);
        media_rx_valid_in = 1'b1;
        media_rx_in = '{s, d};
        for (i = 0; i < 300 && !media_rx_ready_out; i++) tick(1);
        `CHK("push_rdy", 1'b1, media_rx_ready_out);
        tick(1);
        media_rx_valid_in = 1'b0;
    endtask : push
    task automatic do_reset();
        rst_in = 1'b1;
        tick(6);
        rst_in = 1'b0;
        clr = 1'b1;
        tick(3);
        clr = 1'b0;
    endtask : do_reset
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset values, mode table, then the awkward cases
    initial begin
        do_reset();
        `CHK("ser_en", 1'b1, phy_serial_enable_out);
        `CHK("straps", 2'b10, strap_status_one_out);
        `CHK("an_en", 1'b1, serial_autoneg_enable_out);
        `CHK("rxclk", 2'b00, {rx_clk_p_out, rx_clk_n_out});
        for (int i = 0; i < 4; i++) begin
            parallel_enable_in = ROWS[i].par;
            wr_ctl(ROWS[i].ser, 1'b0);
            mac_tx_in = 8'hA0 + 8'(i);
            mac_tx_valid_in = 1'b1;
            tick(3);
            `CHK("mode", ROWS[i].mode, mode_out);
            `CHK("txv", ROWS[i].txv, media_tx_valid_out);
            if (ROWS[i].txv) `CHK("txd", 8'hA0 + 8'(i), media_tx_out);
        end
        wr_ctl(1'b1, 1'b0);
        mac_tx_valid_in = 1'b0;
        tick(3);
        `CHK("tx_one", 1'b0, media_tx_valid_out);
        `CHK("an_word", 16'h9801, an_word_out);
        `CHK("mac_spd", `SGM_SPD_1000, an_speed);
        six_wire_enable_in = 1'b1;
        tick(3);
        a = {7'h00, rx_clk_p_out};
        tick(1);
        `CHK("clk_p", ~a[0], rx_clk_p_out);
        `CHK("clk_n", a[0], rx_clk_n_out);
        six_wire_enable_in = 1'b0;
        // 100 Mb replication with the MAC stalling every other cycle
        media_speed_in = `SGM_SPD_100;
        pace = 2'h1;
        tick(5);
        push(8'h3C, 1'b1);
        push(8'hC5, 1'b0);
        tick(80);
        `CHK("beats100", 16'd20, beats);
        `CHK("sof100", 16'd1, sofs);
        `CHK("last100", 8'hC5, last);
        // 10 Mb stalls until rate adapt is cleared, then 100 copies
        clr = 1'b1;
        pace = 2'h0;
        media_speed_in = `SGM_SPD_10;
        ten_meg_serial_rate_adapt_in = 1'b1;
        tick(5);
        clr = 1'b0;
        push(8'h81, 1'b1);
        tick(30);
        `CHK("stall10", 16'd0, beats);
        ten_meg_serial_rate_adapt_in = 1'b0;
        tick(250);
        `CHK("beats10", 16'd100, beats);
        // Fill the buffer against a stalled MAC, then drain at 1000 Mb
        clr = 1'b1;
        media_speed_in = `SGM_SPD_1000;
        pace = 2'h2;
        acc = 0;
        refused = 1'b0;
        tick(5);
        clr = 1'b0;
        for (int i = 0; i < 12; i++) begin
            media_rx_valid_in = 1'b1;
            media_rx_in = '{1'b0, 8'(i)};
            if (media_rx_ready_out === 1'b1) acc++;
            else refused = 1'b1;
            tick(1);
        end
        media_rx_valid_in = 1'b0;
        `CHK("refused", 1'b1, refused);
        `CHK("fill", 1'b1, acc >= 8 && acc <= 9);
        pace = 2'h0;
        tick(30);
        `CHK("drain", 16'(acc), beats);
        `CHK("empty", 1'b1, media_rx_ready_out);
        // Forced speed freezes, follows the media at a new link
        wr_ctl(1'b0, 1'b1);
        tick(2);
        `CHK("an_off", 2'b00, {serial_autoneg_enable_out, |an_word_out});
        `CHK("forced", `SGM_SPD_1000, serial_speed_out);
        media_speed_in = `SGM_SPD_100;
        tick(5);
        `CHK("frozen", `SGM_SPD_1000, serial_speed_out);
        media_link_in = 1'b0;
        tick(5);
        media_link_in = 1'b1;
        tick(5);
        `CHK("relink", `SGM_SPD_100, serial_speed_out);
        // Loopback speed from the media selection, forced and negotiated
        mdi_speed_sel_in = `SGM_SPD_10;
        mac_loopback_in = 1'b1;
        tick(3);
        `CHK("lb_forced", `SGM_SPD_10, serial_speed_out);
        wr_ctl(1'b1, 1'b1);
        mdi_speed_sel_in = `SGM_SPD_100;
        tick(3);
        `CHK("lb_an", `SGM_SPD_100, serial_speed_out);
        mac_loopback_in = 1'b0;
        // Second reset with the straps flipped
        serial_enable_strap_pin_in = 1'b0;
        parallel_dis_strap_in = 1'b1;
        parallel_enable_in = 1'b1;
        tick(4);
        do_reset();
        `CHK("ser_en2", 1'b0, phy_serial_enable_out);
        `CHK("straps2", 2'b01, strap_status_one_out);
        `CHK("mode2", SGM_MODE_PAR, mode_out);
        wrap_up();
    end
endmodule : sgm_mac_if_tb
